// ==== sora_responder.sv ====
// Top of the responder: telegram parser, dictionary access, reply builder.
// Assumes an external object dictionary that answers each request with one done pulse.
//
// What this block does
// R01 - Read success answers 43h, 4Bh or 4Fh for 32, 16 or 8 bit data.
// R02 - Failed read answers 80h with a 32-bit error cause in data bytes.
// R03 - Reply echoes the request's 16-bit index unchanged.
// R04 - Reply echoes the request's 8-bit sub-index unchanged.
// R05 - Multi-byte fields travel low byte first; 2Bh writes a 16-bit value.
// R06 - Host writes a one-byte object with 2Fh, value in data byte 4.
// R07 - 23h writes a 32-bit value, little-endian across data bytes 4-7.
// R08 - Telegram is ID, eight payload bytes, checksum of negated byte sum.
// R09 - Own ID with bad checksum: discard telegram, send nothing.
// R10 - Host reads an object with 40h, index and sub-index, data unused.
// R11 - Line runs 38400 bit/s, 8 data bits, 1 stop, no parity.
// R12 - Checking and answering start only after all ten bytes arrive.
`timescale 1ns/100ps
`default_nettype none

module sora_responder
    import sora_pkg::*;
#(parameter logic [11:0] BIT_TIME = BIT_CYCLES)
(
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic [7:0]      node_id,
    input  wire logic            rxd,
    output logic                 txd,
    output sora_dict_req_t       dict_req,
    input  wire sora_dict_rsp_t  dict_rsp,
    output logic                 checksum_error,
    output logic                 reply_done
);

    typedef enum logic [2:0] {M_RECV, M_CHECK, M_DICT, M_BUILD, M_SEND} sora_main_state_t;

    sora_main_state_t state_reg,     state_next;
    logic [7:0]       frame_reg [0:9];
    logic [7:0]       frame_next [0:9];
    logic [3:0]       count_reg,     count_next;
    logic [7:0]       sum_reg,       sum_next;
    sora_dict_req_t   req_reg,       req_next;
    logic             tx_start_reg,  tx_start_next;
    logic [7:0]       tx_data_reg,   tx_data_next;
    logic             chk_err_reg,   chk_err_next;
    logic             done_reg,      done_next;
    logic             rx_strobe;
    logic [7:0]       rx_data;
    logic             tx_busy;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] sora_mask(input logic [1:0] size, input logic [31:0] value);
        case (size)
            SIZE_8:  return {24'h000000, value[7:0]};
            SIZE_16: return {16'h0000, value[15:0]};
            default: return value;
        endcase
    endfunction : sora_mask

    // ------------------------------------------------------------
    // Serial line
    // ------------------------------------------------------------
    sora_uart #(.BIT_TIME(BIT_TIME)) u_uart (
        .clk       (clk),
        .arst_n    (arst_n),
        .rxd       (rxd),
        .tx_start  (tx_start_reg),
        .tx_data   (tx_data_reg),
        .rx_strobe (rx_strobe),
        .rx_data   (rx_data),
        .tx_busy   (tx_busy),
        .txd       (txd)
    ); // R11

    // ------------------------------------------------------------
    // Telegram sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0]  cmd;
        logic [31:0] payload;
        logic [31:0] reply_data;
        logic [7:0]  chk;
        cmd        = frame_reg[POS_CMD];
        payload    = {frame_reg[POS_DATA + 3], frame_reg[POS_DATA + 2],
                      frame_reg[POS_DATA + 1], frame_reg[POS_DATA]}; // R05 R07
        reply_data = 32'h00000000;
        chk        = 8'h00;
        state_next    = state_reg;
        frame_next    = frame_reg;
        count_next    = count_reg;
        sum_next      = sum_reg;
        req_next      = req_reg;
        tx_start_next = 1'b0;
        tx_data_next  = tx_data_reg;
        chk_err_next  = 1'b0;
        done_next     = 1'b0;
        case (state_reg)
            M_RECV: begin
                if (rx_strobe) begin
                    frame_next[count_reg] = rx_data;
                    sum_next              = sum_reg + rx_data; // R08
                    if (count_reg == LAST_BYTE) begin
                        count_next = 4'h0;
                        state_next = M_CHECK; // R12
                    end else begin
                        count_next = count_reg + 4'h1;
                    end
                end
            end
            M_CHECK: begin
                sum_next   = 8'h00;
                state_next = M_RECV;
                if (frame_reg[POS_ID] != node_id) begin
                    state_next = M_RECV;
                end else if (sum_reg != 8'h00) begin
                    chk_err_next = 1'b1; // R09
                end else begin
                    req_next.index    = {frame_reg[POS_IDX_HI], frame_reg[POS_IDX_LO]}; // R05
                    req_next.subindex = frame_reg[POS_SUB];
                    state_next        = M_DICT;
                    req_next.valid    = 1'b1;
                    req_next.write    = 1'b1;
                    case (cmd)
                        CMD_READ: begin
                            req_next.write = 1'b0; // R10
                            req_next.size  = SIZE_32;
                            req_next.wdata = 32'h00000000;
                        end
                        CMD_WR32: begin
                            req_next.size  = SIZE_32;
                            req_next.wdata = payload; // R07
                        end
                        CMD_WR16: begin
                            req_next.size  = SIZE_16;
                            req_next.wdata = sora_mask(SIZE_16, payload); // R05
                        end
                        CMD_WR8: begin
                            req_next.size  = SIZE_8;
                            req_next.wdata = sora_mask(SIZE_8, payload); // R06
                        end
                        default: begin
                            req_next.valid      = 1'b0;
                            frame_next[POS_CMD] = RSP_ERR;
                            reply_data          = ERR_CAUSE_BAD_CMD;
                            for (int i = 0; i < 4; i++) begin
                                frame_next[POS_DATA + i] = reply_data[8 * i +: 8];
                            end
                            state_next = M_BUILD;
                        end
                    endcase
                end
            end
            M_DICT: begin
                if (dict_rsp.done) begin
                    req_next.valid = 1'b0;
                    if (dict_rsp.error) begin
                        frame_next[POS_CMD] = RSP_ERR; // R02
                        reply_data          = dict_rsp.rdata; // R02
                    end else if (req_reg.write) begin
                        frame_next[POS_CMD] = RSP_WR_OK;
                    end else begin
                        frame_next[POS_CMD] = (dict_rsp.size == SIZE_8) ? RSP_RD8 :
                                              (dict_rsp.size == SIZE_16) ? RSP_RD16 : RSP_RD32; // R01
                        reply_data          = sora_mask(dict_rsp.size, dict_rsp.rdata); // R01
                    end
                    for (int i = 0; i < 4; i++) begin
                        frame_next[POS_DATA + i] = reply_data[8 * i +: 8]; // R05
                    end
                    state_next = M_BUILD;
                end
            end
            M_BUILD: begin
                // Index bytes stay as received
                for (int i = 0; i < POS_TELEGRAM_CHECKSUM; i++) begin
                    chk = chk - frame_reg[i];
                end
                frame_next[POS_ID]   = node_id;
                frame_next[POS_TELEGRAM_CHECKSUM] = chk - frame_reg[POS_ID] + node_id; // R03 R04 R08
                count_next           = 4'h0;
                state_next           = M_SEND;
            end
            M_SEND: begin
                if (!tx_busy && !tx_start_reg) begin
                    if (count_reg == TELEGRAM_LEN) begin
                        count_next = 4'h0;
                        done_next  = 1'b1;
                        state_next = M_RECV;
                    end else begin
                        tx_start_next = 1'b1;
                        tx_data_next  = frame_reg[count_reg];
                        count_next    = count_reg + 4'h1;
                    end
                end
            end
            default: state_next = M_RECV;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= M_RECV;
            count_reg    <= 4'h0;
            sum_reg      <= 8'h00;
            req_reg      <= '0;
            tx_start_reg <= 1'b0;
            tx_data_reg  <= 8'h00;
            chk_err_reg  <= 1'b0;
            done_reg     <= 1'b0;
            for (int i = 0; i < 10; i++) begin
                frame_reg[i] <= 8'h00;
            end
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            sum_reg      <= sum_next;
            req_reg      <= req_next;
            tx_start_reg <= tx_start_next;
            tx_data_reg  <= tx_data_next;
            chk_err_reg  <= chk_err_next;
            done_reg     <= done_next;
            frame_reg    <= frame_next;
        end
    end

    assign dict_req       = req_reg;
    assign checksum_error = chk_err_reg;
    assign reply_done     = done_reg;

endmodule : sora_responder

`default_nettype wire

// ==== sora_pkg.sv ====
// Shared constants and carrier types of the responder.
// Assumes a 125 MHz system clock and an asynchronous serial line.
package sora_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 125000000;
    localparam int unsigned BAUD_RATE   = 38400;
    localparam logic [11:0] BIT_CYCLES  = 12'((CLK_HZ + BAUD_RATE / 2) / BAUD_RATE);
    localparam logic [2:0]  LAST_BIT    = 3'h7;

    // ------------------------------------------------------------
    // Telegram layout
    // ------------------------------------------------------------
    localparam logic [3:0] TELEGRAM_LEN = 4'ha;
    localparam logic [3:0] LAST_BYTE    = 4'h9;
    localparam int         POS_ID       = 0;
    localparam int         POS_CMD      = 1;
    localparam int         POS_IDX_LO   = 2;
    localparam int         POS_IDX_HI   = 3;
    localparam int         POS_SUB      = 4;
    localparam int         POS_DATA     = 5;
    localparam int         POS_TELEGRAM_CHECKSUM     = 9;

    // ------------------------------------------------------------
    // Command and response codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ    = 8'h40;
    localparam logic [7:0] CMD_WR32    = 8'h23;
    localparam logic [7:0] CMD_WR16    = 8'h2b;
    localparam logic [7:0] CMD_WR8     = 8'h2f;
    localparam logic [7:0] RSP_RD32    = 8'h43;
    localparam logic [7:0] RSP_RD16    = 8'h4b;
    localparam logic [7:0] RSP_RD8     = 8'h4f;
    localparam logic [7:0] RSP_WR_OK   = 8'h60;
    localparam logic [7:0] RSP_ERR     = 8'h80;
    localparam logic [31:0] ERR_CAUSE_BAD_CMD = 32'h0000_0001;

    // ------------------------------------------------------------
    // Object size encoding
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_8  = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
    } sora_dict_req_t;

    typedef struct packed {
        logic        done;
        logic        error;
        logic [1:0]  size;
        logic [31:0] rdata;
    } sora_dict_rsp_t;

endpackage : sora_pkg

// ==== sora_uart.sv ====
// Byte-wide asynchronous serial receiver and transmitter, 8N1.
// Assumes an asynchronous receive pin; it is synchronised here.
`timescale 1ns/100ps
`default_nettype none

module sora_uart
    import sora_pkg::*;
#(parameter logic [11:0] BIT_TIME = BIT_CYCLES)
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       rxd,
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_data,
    output logic            rx_strobe,
    output logic [7:0]      rx_data,
    output logic            tx_busy,
    output logic            txd
);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sora_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sora_tx_state_t;

    logic           rxd_meta_reg;
    logic           rxd_sync_reg;
    sora_rx_state_t rx_state_reg,  rx_state_next;
    logic [11:0]    rx_cnt_reg,    rx_cnt_next;
    logic [2:0]     rx_bit_reg,    rx_bit_next;
    logic [7:0]     rx_shift_reg,  rx_shift_next;
    logic           rx_strobe_reg, rx_strobe_next;
    logic [7:0]     rx_data_reg,   rx_data_next;
    sora_tx_state_t tx_state_reg,  tx_state_next;
    logic [11:0]    tx_cnt_reg,    tx_cnt_next;
    logic [2:0]     tx_bit_reg,    tx_bit_next;
    logic [7:0]     tx_shift_reg,  tx_shift_next;
    logic           txd_reg,       txd_next;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    always_comb begin
        rx_state_next  = rx_state_reg;
        rx_cnt_next    = rx_cnt_reg;
        rx_bit_next    = rx_bit_reg;
        rx_shift_next  = rx_shift_reg;
        rx_strobe_next = 1'b0;
        rx_data_next   = rx_data_reg;
        if (rx_cnt_reg != 12'h000) begin
            rx_cnt_next = rx_cnt_reg - 12'h001;
        end
        case (rx_state_reg)
            RX_IDLE: begin
                if (!rxd_sync_reg) begin
                    rx_cnt_next   = (BIT_TIME >> 1) - 12'h001;
                    rx_state_next = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt_reg == 12'h000) begin
                    rx_cnt_next   = BIT_TIME - 12'h001;
                    rx_bit_next   = 3'h0;
                    rx_state_next = rxd_sync_reg ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cnt_reg == 12'h000) begin
                    rx_shift_next = {rxd_sync_reg, rx_shift_reg[7:1]};
                    rx_cnt_next   = BIT_TIME - 12'h001;
                    rx_bit_next   = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == LAST_BIT) begin
                        rx_state_next = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_cnt_reg == 12'h000) begin
                    rx_strobe_next = rxd_sync_reg;
                    rx_data_next   = rxd_sync_reg ? rx_shift_reg : rx_data_reg;
                    rx_state_next  = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_bit_next   = tx_bit_reg;
        tx_shift_next = tx_shift_reg;
        txd_next      = txd_reg;
        if (tx_cnt_reg != 12'h000) begin
            tx_cnt_next = tx_cnt_reg - 12'h001;
        end
        case (tx_state_reg)
            TX_IDLE: begin
                txd_next = 1'b1;
                if (tx_start) begin
                    tx_shift_next = tx_data;
                    tx_cnt_next   = BIT_TIME - 12'h001;
                    txd_next      = 1'b0;
                    tx_state_next = TX_START;
                end
            end
            TX_START: begin
                if (tx_cnt_reg == 12'h000) begin
                    txd_next      = tx_shift_reg[0];
                    tx_bit_next   = 3'h0;
                    tx_cnt_next   = BIT_TIME - 12'h001;
                    tx_state_next = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_cnt_reg == 12'h000) begin
                    tx_cnt_next = BIT_TIME - 12'h001;
                    if (tx_bit_reg == LAST_BIT) begin
                        txd_next      = 1'b1;
                        tx_state_next = TX_STOP;
                    end else begin
                        tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                        txd_next      = tx_shift_reg[1];
                        tx_bit_next   = tx_bit_reg + 3'h1;
                    end
                end
            end
            TX_STOP: begin
                if (tx_cnt_reg == 12'h000) begin
                    tx_state_next = TX_IDLE;
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg  <= RX_IDLE;
            rx_cnt_reg    <= 12'h000;
            rx_bit_reg    <= 3'h0;
            rx_shift_reg  <= 8'h00;
            rx_strobe_reg <= 1'b0;
            rx_data_reg   <= 8'h00;
            tx_state_reg  <= TX_IDLE;
            tx_cnt_reg    <= 12'h000;
            tx_bit_reg    <= 3'h0;
            tx_shift_reg  <= 8'h00;
            txd_reg       <= 1'b1;
        end else begin
            rx_state_reg  <= rx_state_next;
            rx_cnt_reg    <= rx_cnt_next;
            rx_bit_reg    <= rx_bit_next;
            rx_shift_reg  <= rx_shift_next;
            rx_strobe_reg <= rx_strobe_next;
            rx_data_reg   <= rx_data_next;
            tx_state_reg  <= tx_state_next;
            tx_cnt_reg    <= tx_cnt_next;
            tx_bit_reg    <= tx_bit_next;
            tx_shift_reg  <= tx_shift_next;
            txd_reg       <= txd_next;
        end
    end

    assign rx_strobe = rx_strobe_reg;
    assign rx_data   = rx_data_reg;
    assign tx_busy   = (tx_state_reg != TX_IDLE);
    assign txd       = txd_reg;

endmodule : sora_uart

`default_nettype wire

// ==== sora_responder_assertions.sv ====
// Port checker of the responder.
// Assumes one clock domain and the package's bit timing.
`timescale 1ns/100ps
`default_nettype none
module sora_responder_assertions
    import sora_pkg::*;
#(parameter logic [11:0] BIT_TIME = BIT_CYCLES)
(
    input wire logic           clk,
    input wire logic           arst_n,
    input wire logic [7:0]     node_id,
    input wire logic           rxd,
    input wire logic           txd,
    input wire sora_dict_req_t dict_req,
    input wire sora_dict_rsp_t dict_rsp,
    input wire logic           checksum_error,
    input wire logic           reply_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----
    // Low run length of txd
    // ----
    logic [15:0] low_reg;
    logic [15:0] low_next;
    always_comb begin
        low_next = txd ? 16'h0 : low_reg + 16'h1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_reg <= 16'h0;
        end else begin
            low_reg <= low_next;
        end
    end
    // ----
    // Sequences and assertions
    // ----
    sequence s_req_end;
        dict_req.valid && dict_rsp.done;
    endsequence
    sequence s_quiet;
        (!dict_req.valid && txd) [*8];
    endsequence
    a_read_size: assert property (dict_req.valid && !dict_req.write |-> dict_req.size == SIZE_32)
        else $error("read request size wrong");
    a_req_held: assert property (dict_req.valid && !dict_rsp.done |=> dict_req.valid && $stable(dict_req))
        else $error("request changed while pending");
    a_req_release: assert property (s_req_end |=> !dict_req.valid)
        else $error("request held after done");
    a_tx_waits: assert property (dict_req.valid |-> txd)
        else $error("reply started before dictionary answer");
    a_req_after_rx: assert property ($rose(dict_req.valid) |-> rxd && $past(rxd, 2))
        else $error("request before telegram end");
    a_bad_silent: assert property (checksum_error |-> s_quiet)
        else $error("activity after bad checksum");
    a_cs_pulse: assert property (checksum_error |=> !checksum_error)
        else $error("checksum flag longer than one cycle");
    a_done_pulse: assert property (reply_done |-> txd ##1 !reply_done)
        else $error("reply done malformed");
    a_bit_time: assert property ($rose(txd) |-> (low_reg % BIT_TIME) == 16'h0)
        else $error("txd low run not whole bits");
endmodule : sora_responder_assertions
bind sora_responder sora_responder_assertions #(.BIT_TIME(BIT_TIME)) sora_responder_assertions_inst (
    .clk(clk), .arst_n(arst_n), .node_id(node_id), .rxd(rxd), .txd(txd),
    .dict_req(dict_req), .dict_rsp(dict_rsp), .checksum_error(checksum_error), .reply_done(reply_done)
);
`default_nettype wire

// ==== sora_host.sv ====
// Host model: sends request telegrams and collects replies.
// Assumes 8N1 line timing from the package.
`timescale 1ns/100ps
`default_nettype none
module sora_host
    import sora_pkg::*;
#(parameter logic [11:0] BIT_TIME = BIT_CYCLES)
(
    input  wire logic clk,
    input  wire logic txd,
    output var logic  rxd
);
    logic [79:0] rx_tel;
    initial rxd = 1'b1;
    task automatic put(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
            repeat (BIT_TIME) @(negedge clk);
        end
    endtask : put
    task automatic send_tel(input logic [71:0] t, input logic bad);
        logic [7:0] s = 8'h0;
        for (int k = 8; k >= 0; k--) begin
            s = s + t[k * 8 +: 8];
            put(t[k * 8 +: 8]);
        end
        put((8'h0 - s) ^ {7'h0, bad});
    endtask : send_tel
    task automatic get_tel(input int lim, output logic got);
        int n = 0;
        got = 1'b0;
        for (int k = 0; k < 10; k++) begin
            while (txd !== 1'b0) begin
                if (n++ > lim) return;
                @(negedge clk);
            end
            repeat (BIT_TIME >> 1) @(negedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_TIME) @(negedge clk);
                if (i < 8) rx_tel[(9 - k) * 8 + i] = txd;
            end
            if (txd !== 1'b1) return;
        end
        got = 1'b1;
    endtask : get_tel
endmodule : sora_host
`default_nettype wire

// ==== tb_sora_responder.sv ====
// Testbench: host model on the line, dictionary answered here.
// Assumes a shortened bit time to keep the run short.
`timescale 1ns/100ps
`default_nettype none
module tb_sora_responder;
    import sora_pkg::*;
    localparam logic [7:0] NODE = 8'h01;
    localparam logic [11:0] BT  = 12'h020;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic           rxd;
    logic           txd;
    logic           cs_err;
    logic           done;
    sora_dict_req_t req;
    sora_dict_rsp_t rsp;
    sora_dict_req_t req_seen;
    logic           done_r = 1'b0;
    logic           d_err = 1'b0;
    logic [1:0]     d_size = 2'h0;
    logic [31:0]    d_rdata = 32'h0;
    logic [1:0]     lat = 2'h0;
    int             n_req = 0;
    int             n_cs = 0;
    int             n_errors = 0;
    int             n_tests = 0;
    always #4 clk = ~clk;
    assign rsp = {done_r, d_err, d_size, d_rdata};
    // ----
    // Dictionary answer after four cycles
    // ----
    always @(negedge clk) begin
        done_r <= 1'b0;
        if (cs_err === 1'b1) n_cs <= n_cs + 1;
        if (req.valid === 1'b1 && !done_r) begin
            lat <= lat + 2'h1;
            if (lat == 2'h3) begin
                done_r   <= 1'b1;
                req_seen <= req;
                n_req    <= n_req + 1;
            end
        end
    end
    sora_responder #(.BIT_TIME(BT)) sora_responder_inst (.clk(clk), .arst_n(arst_n), .node_id(NODE), .rxd(rxd),
        .txd(txd), .dict_req(req), .dict_rsp(rsp), .checksum_error(cs_err), .reply_done(done));
    sora_host #(.BIT_TIME(BT)) sora_host_inst (.clk(clk), .txd(txd), .rxd(rxd));
    function automatic logic [31:0] le(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : le
    task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : check
    task automatic xfer(input logic [71:0] t, input logic bad, input logic want, input logic [63:0] exp);
        logic       got;
        logic [7:0] s = NODE;
        fork
            sora_host_inst.send_tel(t, bad);
            sora_host_inst.get_tel(120 * BT, got);
        join
        check("reply present", 80'(want), 80'(got));
        if (want && !got) conclude();
        for (int k = 0; k < 8; k++) s = s + exp[k * 8 +: 8];
        if (want) check("reply", {NODE, exp, 8'h0 - s}, sora_host_inst.rx_tel);
    endtask : xfer
    task automatic sc_read_codes();
        logic [7:0]  code [3] = '{RSP_RD8, RSP_RD16, RSP_RD32};
        logic [31:0] mask [3] = '{32'hff, 32'hffff, 32'hffffffff};
        for (int s = 0; s < 3; s++) begin
            d_size  = 2'(s);
            d_rdata = 32'h8a7b6c5d;
            xfer({NODE, CMD_READ, 16'h4160, 8'(s), 32'h0}, 1'b0, 1'b1,
                 {code[s], 16'h4160, 8'(s), le(32'h8a7b6c5d & mask[s])});
            check("read req", 80'({1'b0, SIZE_32, 16'h6041, 8'(s)}),
                  80'({req_seen.write, req_seen.size, req_seen.index, req_seen.subindex}));
        end
    endtask : sc_read_codes
    task automatic sc_read_err();
        d_err   = 1'b1;
        d_rdata = 32'h06020000;
        xfer({NODE, CMD_READ, 16'h3412, 8'h05, 32'h0}, 1'b0, 1'b1,
             {RSP_ERR, 16'h3412, 8'h05, le(32'h06020000)});
        d_err = 1'b0;
        xfer({NODE, 8'h99, 16'h3412, 8'h05, 32'h0}, 1'b0, 1'b1, {RSP_ERR, 16'h3412, 8'h05, le(ERR_CAUSE_BAD_CMD)});
    endtask : sc_read_err
    task automatic sc_writes();
        logic [7:0]  cmd [3] = '{CMD_WR16, CMD_WR8, CMD_WR32};
        logic [15:0] idx [3] = '{16'h6040, 16'h6060, 16'h607a};
        logic [31:0] val [3] = '{32'h2f, 32'h6, 32'hc350};
        logic [1:0]  sz [3]  = '{SIZE_16, SIZE_8, SIZE_32};
        for (int w = 0; w < 3; w++) begin
            xfer({NODE, cmd[w], idx[w][7:0], idx[w][15:8], 8'h00, le(val[w])}, 1'b0, 1'b1,
                 {RSP_WR_OK, idx[w][7:0], idx[w][15:8], 8'h00, 32'h0});
            check("write req", 80'({1'b1, sz[w], idx[w], val[w]}),
                  80'({req_seen.write, req_seen.size, req_seen.index, req_seen.wdata}));
        end
    endtask : sc_writes
    task automatic sc_bad_frames();
        int r0 = n_req;
        int c0 = n_cs;
        xfer({NODE, CMD_READ, 16'h4160, 8'h00, 32'h0}, 1'b1, 1'b0, 64'h0);
        check("discard", 80'({32'h0, 32'h1}), 80'({n_req - r0, n_cs - c0}));
        xfer({NODE + 8'h1, CMD_READ, 16'h4160, 8'h00, 32'h0}, 1'b0, 1'b0, 64'h0);
        check("foreign", 80'({32'h0, 32'h1}), 80'({n_req - r0, n_cs - c0}));
    endtask : sc_bad_frames
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        sc_read_codes();
        sc_bad_frames();
        sc_read_err();
        sc_writes();
        conclude();
    end
endmodule : tb_sora_responder
`default_nettype wire
